//--- apspc_top.sv
// Position controller with address pin probing, switch sensing and an APB register slave.
// Assumes APB on clk_in; comparator and fault pins are asynchronous and get synchronised here.
`timescale 1ns/1ps
module apspc_top
  import apspc_pkg::*;
#(
  parameter int PERIOD_CYC = PROBE_PERIOD_US * CLK_MHZ,
  parameter int PULSE_CYC = PROBE_PULSE_US * CLK_MHZ,
  parameter int DEB_CYC = PROBE_DEB_US * CLK_MHZ,
  parameter int FLOAT_CYC = FLOAT_DEB_MS * 1000 * CLK_MHZ,
  parameter int STATUS_CYC = STATUS_US * CLK_MHZ,
  parameter int POWERUP_CYC = POWERUP_MS * 1000 * CLK_MHZ
)(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic addr_probe_cmp_in,
  input wire logic switch_probe_cmp_in,
  input wire logic thermal_shutdown_in,
  input wire logic elec_fault_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic high_side_probe_out,
  output logic low_side_probe_out,
  output logic step_out,
  output logic dir_out,
  output logic bridge_enable_out,
  output logic addr_bit_out,
  output logic addr_float_out
);
  localparam int HALF_CYC = PERIOD_CYC / 2;

  function automatic logic [15:0] wrap_pos(input logic [15:0] p, input logic [1:0] m);
    logic [15:0] r;
    r = p;
    case (m)
      MODE_HALF: r = {{3{p[12]}}, p[12:0]};
      MODE_QUARTER: r = {{2{p[13]}}, p[13:0]};
      MODE_EIGHTH: r = {p[14], p[14:0]};
      default: r = p;
    endcase
    return r;
  endfunction : wrap_pos

  logic [17:0] phase_r;
  logic hs_r;
  logic ls_r;
  logic [23:0] pwr_cnt_r;
  logic ready_r;
  logic [17:0] stat_cnt_r;
  logic [7:0] status_r;
  logic [1:0] mode_r;
  logic [10:0] secure_position_r;
  logic [15:0] act_r;
  logic [15:0] tgt_r;
  logic [15:0] pos_snap_r;
  logic sw_flag_r;
  logic [15:0] step_cnt_r;
  logic halting_r;
  logic [3:0] decel_r;
  logic therm_halt_r;
  logic shutdown_r;
  logic dir_r;
  logic step_r;
  logic bridge_r;
  logic therm_prev_r;
  apspc_pin_t addr_prev_r;
  logic armed_r;
  logic [23:0] float_cnt_r;
  logic addr_bit_r;
  logic addr_float_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  wire logic hw_deb;
  wire logic sw_deb;
  wire logic therm_lvl;
  wire logic elec_lvl;
  apspc_pin_t addr_state;

  apspc_sync_deb #(.DEB_CYC(DEB_CYC)) u_hw_deb (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(addr_probe_cmp_in),
    .level_out(hw_deb)
  );
  apspc_sync_deb #(.DEB_CYC(DEB_CYC)) u_sw_deb (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(switch_probe_cmp_in),
    .level_out(sw_deb)
  );
  apspc_sync_deb #(.DEB_CYC(1)) u_therm (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(thermal_shutdown_in),
    .level_out(therm_lvl)
  );
  apspc_sync_deb #(.DEB_CYC(1)) u_elec (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(elec_fault_in),
    .level_out(elec_lvl)
  );

  // Probe schedule: high side at the start of each period, low side at mid period
  wire logic phase_end = (phase_r == 18'(PERIOD_CYC - 1));
  wire logic hs_win = (phase_r < 18'(PULSE_CYC));
  wire logic ls_win = (phase_r >= 18'(HALF_CYC)) && (phase_r < 18'(HALF_CYC + PULSE_CYC));
  wire logic eval_hs = (phase_r == 18'(PULSE_CYC - 1));
  wire logic eval_ls = (phase_r == 18'(HALF_CYC + PULSE_CYC - 1));
  wire logic eval = eval_hs || eval_ls;

  apspc_pin_fsm u_addr_fsm (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .eval_in(eval),
    .high_side_in(eval_hs),
    .cmp_in(hw_deb),
    .state_out(addr_state)
  );

  // APB decode; one wait state so read data and pready both leave flops
  wire logic apb_acc = psel_in && penable_in && !pready_r;
  wire logic apb_done = psel_in && penable_in && pready_r;
  wire logic wr_en = apb_done && pwrite_in && !pslverr_r;
  wire logic hit_ctrl = (paddr_in == OFS_CTRL);
  wire logic hit_move = (paddr_in == OFS_MOVE);
  wire logic hit_pos = (paddr_in == OFS_POS);
  wire logic hit_status = (paddr_in == OFS_STATUS);
  wire logic hit_secure_position = (paddr_in == OFS_SECURE_POSITION);
  wire logic hit_any = hit_ctrl || hit_move || hit_pos || hit_status || hit_secure_position;
  wire logic [31:0] rd_data =
    hit_ctrl ? {30'h0000_0000, mode_r} :
    hit_move ? {16'h0000, tgt_r} :
    hit_pos ? {15'h0000, sw_flag_r, pos_snap_r} :
    hit_status ? {24'h00_0000, status_r} :
    hit_secure_position ? {21'h00_0000, secure_position_r} : 32'h0000_0000;

  // Motion decisions
  wire logic cmd_ok = ready_r && !therm_lvl && !elec_lvl && !halting_r;
  wire logic [15:0] diff = wrap_pos(tgt_r - act_r, mode_r);
  wire logic moving = (diff != 16'h0000);
  wire logic tick = (step_cnt_r == 16'(STEP_CYC - 1));
  wire logic halt_req = wr_en && hit_ctrl && pwdata_in[CTRL_HALT_BIT] && !halting_r;
  wire logic therm_rise = therm_lvl && !therm_prev_r && !halting_r;
  wire logic step_go = tick && !shutdown_r && ready_r && moving && (!halting_r || (decel_r != 4'h0));
  wire logic halt_done = tick && halting_r && ((decel_r == 4'h0) || !moving);
  wire logic dir_now = halting_r ? dir_r : diff[15];
  wire logic [15:0] act_step = dir_now ? act_r - 16'h0001 : act_r + 16'h0001;
  wire logic sec_enabled = (secure_position_r != SECURE_POSITION_OFF);
  wire logic float_done = (float_cnt_r == 24'(FLOAT_CYC - 1));
  wire logic sec_go = armed_r && float_done && sec_enabled && cmd_ok;
  wire logic move_go = wr_en && hit_move && cmd_ok;
  wire logic lost_pin = (addr_prev_r == PIN_HIGH) && (addr_state == PIN_FLOAT);
  wire logic [15:0] sec_tgt = wrap_pos({{5{secure_position_r[10]}}, secure_position_r}, mode_r);
  wire logic [15:0] tgt_nxt =
    halt_done ? act_r :
    sec_go ? sec_tgt :
    move_go ? wrap_pos(pwdata_in[15:0], mode_r) : tgt_r;
  wire logic shutdown_nxt =
    // A hot part must not leave a halt that was already running with the bridges on
    (halt_done && (therm_halt_r || therm_lvl)) ? 1'b1 :
    (sec_go || move_go) ? 1'b0 : shutdown_r;
  wire logic [7:0] status_live = {armed_r, ready_r, therm_lvl, shutdown_r, moving, sw_flag_r, addr_state};

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_r <= 18'h0_0000;
      hs_r <= 1'b0;
      ls_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_end ? 18'h0_0000 : phase_r + 18'h0_0001;
      hs_r <= hs_win;
      ls_r <= ls_win;
    end
  end

  // Power-up phase and periodic status refresh
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pwr_cnt_r <= 24'h00_0000;
      ready_r <= 1'b0;
      stat_cnt_r <= 18'h0_0000;
      status_r <= 8'h00;
    end
    else
    begin
      if (pwr_cnt_r == 24'(POWERUP_CYC - 1))
        ready_r <= 1'b1;
      else
        pwr_cnt_r <= pwr_cnt_r + 24'h00_0001;
      if (stat_cnt_r == 18'(STATUS_CYC - 1))
      begin
        stat_cnt_r <= 18'h0_0000;
        status_r <= status_live;
      end
      else
        stat_cnt_r <= stat_cnt_r + 18'h0_0001;
    end
  end

  // Switch flag and position are captured together, only at probe pulse ends
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sw_flag_r <= 1'b0;
      pos_snap_r <= 16'h0000;
    end
    else if (eval)
    begin
      sw_flag_r <= sw_deb;
      pos_snap_r <= act_r;
    end
  end

  // Secure move: only a loss after a resolved High counts, and only after long float
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      addr_prev_r <= PIN_FLOAT;
      armed_r <= 1'b0;
      float_cnt_r <= 24'h00_0000;
    end
    else
    begin
      addr_prev_r <= addr_state;
      if (lost_pin)
      begin
        armed_r <= 1'b1;
        float_cnt_r <= 24'h00_0000;
      end
      else if (addr_state != PIN_FLOAT || (armed_r && float_done && (sec_go || !sec_enabled)))
      begin
        armed_r <= 1'b0;
        float_cnt_r <= 24'h00_0000;
      end
      else if (armed_r && !float_done)
        float_cnt_r <= float_cnt_r + 24'h00_0001;
    end
  end

  // Motion engine; a gentle halt runs a deceleration tail of up to DECEL_STEPS steps, ending early once the target is reached
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      act_r <= 16'h0000;
      tgt_r <= 16'h0000;
      step_cnt_r <= 16'h0000;
      halting_r <= 1'b0;
      decel_r <= 4'h0;
      therm_halt_r <= 1'b0;
      shutdown_r <= 1'b1;
      dir_r <= 1'b0;
      step_r <= 1'b0;
      bridge_r <= 1'b0;
      therm_prev_r <= 1'b0;
    end
    else
    begin
      therm_prev_r <= therm_lvl;
      step_cnt_r <= tick ? 16'h0000 : step_cnt_r + 16'h0001;
      step_r <= step_go;
      tgt_r <= tgt_nxt;
      shutdown_r <= shutdown_nxt;
      bridge_r <= !shutdown_r;
      if (step_go)
      begin
        act_r <= wrap_pos(act_step, mode_r);
        dir_r <= dir_now;
      end
      if (halt_req || therm_rise)
      begin
        halting_r <= 1'b1;
        decel_r <= DECEL_STEPS;
        therm_halt_r <= therm_rise;
      end
      else if (halt_done)
      begin
        halting_r <= 1'b0;
        therm_halt_r <= 1'b0;
      end
      else if (step_go && halting_r)
        decel_r <= decel_r - 4'h1;
    end
  end

  // Registers and APB answer
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_r <= MODE_RST;
      secure_position_r <= SECURE_POSITION_RST;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      addr_bit_r <= 1'b0;
      addr_float_r <= 1'b1;
    end
    else
    begin
      pready_r <= apb_acc;
      pslverr_r <= apb_acc && !hit_any;
      prdata_r <= (apb_acc && !pwrite_in) ? rd_data : 32'h0000_0000;
      if (wr_en && hit_ctrl)
        mode_r <= pwdata_in[1:0];
      if (wr_en && hit_secure_position)
        secure_position_r <= pwdata_in[10:0];
      addr_bit_r <= (addr_state == PIN_HIGH);
      addr_float_r <= (addr_state == PIN_FLOAT);
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign high_side_probe_out = hs_r;
  assign low_side_probe_out = ls_r;
  assign step_out = step_r;
  assign dir_out = dir_r;
  assign bridge_enable_out = bridge_r;
  assign addr_bit_out = addr_bit_r;
  assign addr_float_out = addr_float_r;

  a_probe_exclusive: assert property (@(posedge clk_in) disable iff (rst_in) !(hs_r && ls_r))
    else $error("Both probe switches closed");
  a_hs_to_low: assert property (@(posedge clk_in) disable iff (rst_in) eval_hs && hw_deb |=> addr_state == PIN_LOW)
    else $error("High-side hit did not give Low");
  a_ls_to_high: assert property (@(posedge clk_in) disable iff (rst_in) eval_ls && hw_deb |=> addr_state == PIN_HIGH)
    else $error("Low-side hit did not give High");
  a_addr_bit_map: assert property (@(posedge clk_in) disable iff (rst_in)
    addr_state == PIN_HIGH |=> addr_bit_out && !addr_float_out)
    else $error("High state not shown as bit one");
  a_pair_latched: assert property (@(posedge clk_in) disable iff (rst_in)
    eval |=> pos_snap_r == $past(act_r) && sw_flag_r == $past(sw_deb))
    else $error("Switch and position pair not captured together");
  a_pair_stable: assert property (@(posedge clk_in) disable iff (rst_in) !eval |=> $stable(pos_snap_r))
    else $error("Position snapshot moved between probe pulses");
  a_secure_disabled: assert property (@(posedge clk_in) disable iff (rst_in)
    secure_position_r == SECURE_POSITION_OFF && armed_r && float_done && !move_go && !halt_done
    |=> tgt_r == $past(tgt_r) && !armed_r)
    else $error("Secure move while disabled");
  a_halt_target: assert property (@(posedge clk_in) disable iff (rst_in) halt_done |=> tgt_r == $past(act_r))
    else $error("Target not loaded at halt end");
  a_no_step_early: assert property (@(posedge clk_in) disable iff (rst_in) !ready_r |=> !step_out)
    else $error("Step during power-up");
  a_bridge_off: assert property (@(posedge clk_in) disable iff (rst_in) shutdown_r [*2] |-> !bridge_enable_out)
    else $error("Bridges enabled in shutdown");
  a_therm_shutdown: assert property (@(posedge clk_in) disable iff (rst_in)
    halt_done && therm_halt_r |=> shutdown_r)
    else $error("Thermal halt did not enter shutdown");
endmodule : apspc_top

//--- apspc_pkg.sv
// Constants, field layout and types of the position controller with address pin sensing.
// Assumes a 250 MHz core clock; the derived cycle counts live in the top-level parameters.
package apspc_pkg;
  localparam int CLK_MHZ = 250;
  localparam int PROBE_DEB_US = 32;
  localparam int PROBE_PERIOD_US = 1024;
  localparam int PROBE_PULSE_US = 128;
  localparam int FLOAT_DEB_MS = 64;
  localparam int STATUS_US = 512;
  localparam int POWERUP_MS = 10;
  localparam int STEP_CYC = 1000;
  localparam logic [3:0] DECEL_STEPS = 4'h8;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MOVE = 8'h04;
  localparam logic [7:0] OFS_POS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_SECURE_POSITION = 8'h10;

  localparam int CTRL_HALT_BIT = 4;
  localparam int POS_SW_BIT = 16;
  localparam int ST_SW_BIT = 2;
  localparam int ST_MOVING_BIT = 3;
  localparam int ST_SHUTDOWN_BIT = 4;
  localparam int ST_THERM_BIT = 5;
  localparam int ST_READY_BIT = 6;
  localparam int ST_ARMED_BIT = 7;

  localparam logic [1:0] MODE_HALF = 2'b00;
  localparam logic [1:0] MODE_QUARTER = 2'b01;
  localparam logic [1:0] MODE_EIGHTH = 2'b10;
  localparam logic [1:0] MODE_RST = 2'b00;
  localparam logic [10:0] SECURE_POSITION_OFF = 11'h400;
  localparam logic [10:0] SECURE_POSITION_RST = 11'h400;

  typedef enum logic [1:0] {
    PIN_LOW = 2'b00,
    PIN_HIGH = 2'b01,
    PIN_FLOAT = 2'b10
  } apspc_pin_t;
endpackage : apspc_pkg

//--- apspc_sync_deb.sv
// Two-flop synchroniser followed by a stability debounce.
// Assumes the pin is asynchronous to clk_in; DEB_CYC must fit 16 bits.
`timescale 1ns/1ps
module apspc_sync_deb #(
  parameter int DEB_CYC = 1
)(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out
);
  logic [1:0] sync_r;
  logic [15:0] cnt_r;
  logic level_r;

  // The first stage feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync_r <= 2'b00;
      cnt_r <= 16'h0000;
      level_r <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[0], pin_in};
      if (sync_r[1] == level_r)
        cnt_r <= 16'h0000;
      else if (cnt_r == 16'(DEB_CYC - 1))
      begin
        level_r <= sync_r[1];
        cnt_r <= 16'h0000;
      end
      else
        cnt_r <= cnt_r + 16'h0001;
    end
  end

  assign level_out = level_r;
endmodule : apspc_sync_deb

//--- apspc_pin_fsm.sv
// Three-state interpreter of the address pin comparator.
// Assumes eval_in pulses once at the end of each probe pulse with a debounced comparator.
`timescale 1ns/1ps
module apspc_pin_fsm
  import apspc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic eval_in,
  input wire logic high_side_in,
  input wire logic cmp_in,
  output apspc_pin_t state_out
);
  apspc_pin_t state_r;
  apspc_pin_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    if (eval_in)
    begin
      case (state_r)
        PIN_LOW:
          if (high_side_in)
            state_nxt = cmp_in ? PIN_LOW : PIN_FLOAT;
          else
            state_nxt = cmp_in ? PIN_HIGH : PIN_LOW;
        PIN_HIGH:
          if (high_side_in)
            state_nxt = cmp_in ? PIN_LOW : PIN_HIGH;
          else
            state_nxt = cmp_in ? PIN_HIGH : PIN_FLOAT;
        PIN_FLOAT:
          if (high_side_in)
            state_nxt = cmp_in ? PIN_LOW : PIN_FLOAT;
          else
            state_nxt = cmp_in ? PIN_HIGH : PIN_FLOAT;
        default:
          state_nxt = PIN_FLOAT;
      endcase
    end
  end

  // Starts unresolved so that reset alone never looks like a lost pin
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_r <= PIN_FLOAT;
    else
      state_r <= state_nxt;
  end

  assign state_out = state_r;
endmodule : apspc_pin_fsm

//--- apspc_pin_model.sv
// Behavioural model of the hardwired address pin and the external switch.
// Assumes probe controls come straight from the controller; no probe closed means no current.
`timescale 1ns/1ps
module apspc_pin_model (
  input wire logic high_side_in,
  input wire logic low_side_in,
  input wire logic [1:0] conn_in,
  input wire logic sw_closed_in,
  output logic addr_cmp_out,
  output logic sw_cmp_out
);
  // conn_in: 0 resistor to ground, 1 resistor to battery, 2 open
  wire logic to_gnd;
  wire logic to_bat;
  assign to_gnd = (conn_in == 2'h0);
  assign to_bat = (conn_in == 2'h1);
  // Top probe sees current to ground, bottom probe current to battery
  assign addr_cmp_out = (high_side_in & to_gnd) | (low_side_in & to_bat);
  // Closed switch conducts on either probe; comparator is low between pulses
  assign sw_cmp_out = sw_closed_in & (high_side_in | low_side_in);
endmodule : apspc_pin_model

//--- apspc_top_tb.sv
// Self-checking bench of the position controller: APB master, pin and switch model.
// Assumes shortened probe, debounce and power-up counts; electrical fault input raised once in the thermal scenario.
`timescale 1ns/1ps
module apspc_top_tb
  import apspc_pkg::*;
;
  localparam int PER = 400;
  localparam int PUL = 50;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] conn = 2'h2;
  logic sw_closed = 1'b0;
  logic thermal = 1'b0;
  logic elec = 1'b0;
  logic addr_cmp;
  logic sw_cmp;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hs;
  logic ls;
  logic step;
  logic dir;
  logic bridge;
  logic abit;
  logic afloat;
  logic last_dir = 1'b0;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int checks_done = 0;
  int step_cnt = 0;

  apspc_top #(.PERIOD_CYC(PER), .PULSE_CYC(PUL), .DEB_CYC(8), .FLOAT_CYC(1000), .STATUS_CYC(100),
    .POWERUP_CYC(20)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .addr_probe_cmp_in(addr_cmp),
    .switch_probe_cmp_in(sw_cmp), .thermal_shutdown_in(thermal), .elec_fault_in(elec),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .high_side_probe_out(hs),
    .low_side_probe_out(ls), .step_out(step), .dir_out(dir), .bridge_enable_out(bridge),
    .addr_bit_out(abit), .addr_float_out(afloat));

  apspc_pin_model u_pin (.high_side_in(hs), .low_side_in(ls), .conn_in(conn), .sw_closed_in(sw_closed),
    .addr_cmp_out(addr_cmp), .sw_cmp_out(sw_cmp));

  always #2 clk_in = ~clk_in;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task report_and_stop;
    if (err_total == 0 && checks_done > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Steps are counted here so every scenario can judge travel and direction
  always @(posedge clk_in)
  begin
    if (step === 1'b1)
    begin
      step_cnt <= step_cnt + 1;
      last_dir <= dir;
    end
    if (hs === 1'b1 && ls === 1'b1)
    begin
      check("probe overlap", 32'h0000_0001, 32'h0000_0000);
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      check("apb ready", 32'h0000_0000, 32'h0000_0001);
      report_and_stop;
    end
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd & m, exp);
  endtask : rd_chk

  task automatic wait_steps(input int n, input int lim);
    int i;
    i = 0;
    while (step_cnt < n && i < lim)
    begin
      @(posedge clk_in);
      i++;
    end
    if (step_cnt < n)
    begin
      check("step wait", step_cnt, n);
      report_and_stop;
    end
  endtask : wait_steps

  task automatic probe_timing;
    int nh;
    int rh;
    int nl;
    int rl;
    logic ph;
    logic pl;
    nh = 0;
    rh = 0;
    nl = 0;
    rl = 0;
    ph = hs;
    pl = ls;
    repeat (2 * PER)
    begin
      @(posedge clk_in);
      nh += (hs === 1'b1);
      rh += (hs === 1'b1 && ph !== 1'b1);
      nl += (ls === 1'b1);
      rl += (ls === 1'b1 && pl !== 1'b1);
      ph = hs;
      pl = ls;
    end
    check("hs pulses", rh, 2);
    check("hs high cycles", nh, 2 * PUL);
    check("ls pulses", rl, 2);
    check("ls high cycles", nl, 2 * PUL);
  endtask : probe_timing

  task reset_vals;
    check("float at reset", afloat, 1'h1);
    check("bridge at reset", bridge, 1'h0);
    apb(1'b1, OFS_MOVE, 32'h0000_0005);
    rd_chk(OFS_MOVE, 32'h0000_FFFF, 32'h0000_0000, "move in power-up");
    rd_chk(OFS_SECURE_POSITION, 32'h0000_07FF, 32'h0000_0400, "secure_position reset");
    rd_chk(OFS_CTRL, 32'h0000_0003, 32'h0000_0000, "mode reset");
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped err", er, 1'h1);
    check("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, OFS_SECURE_POSITION, 32'h0000_0003);
    repeat (1500) @(posedge clk_in);
    check("steps from reset float", step_cnt, 0);
    rd_chk(OFS_MOVE, 32'h0000_FFFF, 32'h0000_0000, "no secure from reset");
    rd_chk(OFS_STATUS, 32'h0000_007F, 32'h0000_0052, "idle status");
  endtask : reset_vals

  task pin_states;
    conn <= 2'h1;
    repeat (2 * PER) @(posedge clk_in);
    check("battery bit", abit, 1'h1);
    check("battery float", afloat, 1'h0);
    probe_timing;
    conn <= 2'h0;
    repeat (2 * PER) @(posedge clk_in);
    check("ground bit", abit, 1'h0);
    check("ground float", afloat, 1'h0);
    conn <= 2'h2;
    repeat (2 * PER) @(posedge clk_in);
    check("low to float", afloat, 1'h1);
    repeat (1500) @(posedge clk_in);
    // Losing the pin from Low must not start a secure move
    check("steps from low", step_cnt, 0);
    rd_chk(OFS_MOVE, 32'h0000_FFFF, 32'h0000_0000, "no secure from low");
  endtask : pin_states

  task secure_move;
    conn <= 2'h1;
    repeat (2 * PER) @(posedge clk_in);
    conn <= 2'h2;
    repeat (900) @(posedge clk_in);
    check("secure before debounce", step_cnt, 0);
    wait_steps(3, 5000);
    check("secure dir", last_dir, 1'h0);
    repeat (2500) @(posedge clk_in);
    check("secure steps", step_cnt, 3);
    rd_chk(OFS_MOVE, 32'h0000_FFFF, 32'h0000_0003, "secure target");
    apb(1'b1, OFS_SECURE_POSITION, 32'h0000_0400);
    conn <= 2'h1;
    repeat (2 * PER) @(posedge clk_in);
    conn <= 2'h2;
    repeat (2500) @(posedge clk_in);
    check("secure disabled", step_cnt, 3);
  endtask : secure_move

  task shortest_and_halt;
    // Target code 0x1000 is -4096 in half step; the way up is shorter from +3
    apb(1'b1, OFS_MOVE, 32'h0000_1000);
    wait_steps(4, 1200);
    check("wrap dir", last_dir, 1'h0);
    apb(1'b1, OFS_CTRL, 32'h0000_0010);
    repeat (10000) @(posedge clk_in);
    check("halt steps", step_cnt, 12);
    rd_chk(OFS_MOVE, 32'h0000_FFFF, 32'h0000_000C, "halt target");
    rd_chk(OFS_POS, 32'h0001_FFFF, 32'h0000_000C, "halt pos");
  endtask : shortest_and_halt

  task resume_switch;
    sw_closed <= 1'b1;
    apb(1'b1, OFS_MOVE, 32'h0000_000A);
    wait_steps(14, 2500);
    check("resume dir", last_dir, 1'h1);
    repeat (1500) @(posedge clk_in);
    check("resume steps", step_cnt, 14);
    rd_chk(OFS_POS, 32'h0001_FFFF, 32'h0001_000A, "pos with switch");
    rd_chk(OFS_STATUS, 32'h0000_000F, 32'h0000_0006, "status switch");
    sw_closed <= 1'b0;
    repeat (PER + 200) @(posedge clk_in);
    rd_chk(OFS_STATUS, 32'h0000_0004, 32'h0000_0000, "status refresh");
  endtask : resume_switch

  task thermal_stop;
    apb(1'b1, OFS_MOVE, 32'h0000_0064);
    wait_steps(15, 1200);
    thermal <= 1'b1;
    repeat (10000) @(posedge clk_in);
    check("thermal steps", step_cnt, 23);
    check("thermal bridge", bridge, 1'h0);
    rd_chk(OFS_STATUS, 32'h0000_0030, 32'h0000_0030, "thermal status");
    apb(1'b1, OFS_MOVE, 32'h0000_0032);
    repeat (1500) @(posedge clk_in);
    // Motion must stay refused while the temperature is too high
    check("move in thermal", step_cnt, 23);
    thermal <= 1'b0;
    elec <= 1'b1;
    repeat (10) @(posedge clk_in);
    apb(1'b1, OFS_MOVE, 32'h0000_0028);
    repeat (1500) @(posedge clk_in);
    check("move in fault", step_cnt, 23);
    elec <= 1'b0;
    repeat (10) @(posedge clk_in);
    apb(1'b1, OFS_MOVE, 32'h0000_0018);
    wait_steps(24, 1200);
    check("move after stop", last_dir, 1'h0);
    check("bridge when moving", bridge, 1'h1);
  endtask : thermal_stop

  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    reset_vals;
    pin_states;
    secure_move;
    shortest_and_halt;
    resume_switch;
    thermal_stop;
    report_and_stop;
  end
endmodule : apspc_top_tb
